// [hw/pevif_pkg.sv]
package pevif_pkg;

  // Management register offsets, in 5-bit register address space.
  localparam logic [4:0] PEVIF_OFF_CTRL = 5'h11;
  localparam logic [4:0] PEVIF_OFF_PRIMARY = 5'h12;
  localparam logic [4:0] PEVIF_OFF_SECONDARY = 5'h13;

  // Reset values.
  localparam logic [15:0] PEVIF_RST_PRIMARY = 16'h0000;
  localparam logic [15:0] PEVIF_RST_SECONDARY = 16'h0000;
  localparam logic [3:0] PEVIF_RST_CTRL = 4'h8;

  // Layout of an event register: flags in the upper byte, enables in the lower.
  localparam int PEVIF_FLAG_LSB = 8;
  localparam int PEVIF_FLAG_W = 8;
  localparam int PEVIF_EN_LSB = 0;

  // Control register bit positions.
  localparam int PEVIF_CTRL_POL = 3;
  localparam int PEVIF_CTRL_TEST = 2;
  localparam int PEVIF_CTRL_GEN = 1;
  localparam int PEVIF_CTRL_OE = 0;
  localparam int PEVIF_CTRL_W = 4;

  // Event pulses from the transceiver's sources, one cycle each.
  typedef struct packed {
    logic link_quality;
    logic energy_detect;
    logic link_status;
    logic speed;
    logic duplex;
    logic autoneg_done;
    logic false_carrier_half;
    logic rx_error_half;
    logic eee_error;
    logic autoneg_error;
    logic page_received;
    logic loopback_fifo_err;
    logic crossover;
    logic sleep;
    logic polarity_inverted;
    logic wol_packet;
    logic jabber;
  } pevif_evt_t;

  // One management register access.
  typedef struct packed {
    logic rd;
    logic wr;
    logic [4:0] addr;
    logic [15:0] wdata;
  } pevif_req_t;

endpackage

// [hw/pevif_top.sv]
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// R1 - Bit 15 of primary flags latches on link quality change while link up.
// R2 - Bit 14 of primary flags latches on energy detection change.
// R3 - Bit 13 of primary flags latches on link status change.
// R4 - Bit 12 of primary flags latches on resolved speed change.
// R5 - Bit 11 of primary flags latches on duplex change.
// R6 - Bit 10 of primary flags latches on auto-negotiation completion.
// R7 - Bit 9 of primary flags latches when false-carrier counter passes half-full.
// R8 - Bit 8 of primary flags latches when receive-error counter passes half-full.
// R9 - Primary bits 7..0 are read/write enables for flags eight positions higher.
// R10 - Bit 15 of secondary flags latches on an energy-efficient-ethernet error.
// R11 - Bit 14 of secondary flags latches on auto-negotiation error.
// R12 - Bit 13 of secondary flags latches when a negotiation page arrives.
// R13 - Bit 12 of secondary flags latches on loopback FIFO overflow or underflow.
// R14 - Bit 11 of secondary flags latches on crossover state change.
// R15 - Bit 10 of secondary flags latches on a sleep-mode event.
// R16 - Bit 9 of secondary flags latches on inverted polarity or wake packet.
// R17 - Bit 8 of secondary flags latches on jabber detection.
// R18 - Secondary bits 7..0 are read/write enables, reset to zero.
// R19 - Global enable gates every event-based interrupt.
// R20 - Polarity bit, reset one, selects idle-high/active-low or the reverse.
// R21 - Test bit forces an interrupt for as long as it stays set.
// R22 - Output-enable bit makes the shared pin an interrupt output, else power-down input.
// R23 - Flags clear when their register is read; enables untouched by reads.
// R24 - Interrupt asserts while global enable and some flag with its enable set.
module pevif_top (
  // Clock, reset and clock enable.
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic CE,
  // Management register access.
  input wire pevif_pkg::pevif_req_t REQ,
  output logic [15:0] RDATA,
  output logic RVALID,
  // Event pulses from the transceiver.
  input wire pevif_pkg::pevif_evt_t EVT,
  // Shared interrupt or power-down pin.
  input wire logic IRQ_OR_POWERDOWN_PIN_I,
  output logic IRQ_OR_POWERDOWN_PIN_O,
  output logic IRQ_OR_POWERDOWN_PIN_OE_N,
  output logic POWERDOWN_LEVEL,
  output logic IRQ_ACTIVE
);
  import pevif_pkg::*;

  function automatic logic hit(input pevif_req_t r, input logic [4:0] off);
    hit = r.addr == off;
  endfunction

  function automatic logic [PEVIF_FLAG_W-1:0] primary_events(input pevif_evt_t e);
    primary_events = {e.link_quality, e.energy_detect, e.link_status, e.speed,
                      e.duplex, e.autoneg_done, e.false_carrier_half, e.rx_error_half};
  endfunction

  function automatic logic [PEVIF_FLAG_W-1:0] secondary_events(input pevif_evt_t e);
    secondary_events = {e.eee_error, e.autoneg_error, e.page_received,
                        e.loopback_fifo_err, e.crossover, e.sleep,
                        e.polarity_inverted | e.wol_packet, e.jabber};
  endfunction

  logic [PEVIF_FLAG_W-1:0] flags1_q;
  logic [PEVIF_FLAG_W-1:0] flags1_d;
  logic [PEVIF_FLAG_W-1:0] flags2_q;
  logic [PEVIF_FLAG_W-1:0] flags2_d;
  logic [PEVIF_FLAG_W-1:0] en1_q;
  logic [PEVIF_FLAG_W-1:0] en2_q;
  logic [PEVIF_FLAG_W-1:0] ev1;
  logic [PEVIF_FLAG_W-1:0] ev2;
  logic [PEVIF_CTRL_W-1:0] ctrl_q;
  logic clr1;
  logic clr2;
  logic wr1;
  logic wr2;
  logic wrc;
  logic irq_active;
  logic irq_pin_q;
  logic pd_level_q;
  logic [15:0] rdata_q;
  logic rvalid_q;

  assign ev1 = primary_events(EVT);
  assign ev2 = secondary_events(EVT);

  assign clr1 = CE && REQ.rd && hit(REQ, PEVIF_OFF_PRIMARY);
  assign clr2 = CE && REQ.rd && hit(REQ, PEVIF_OFF_SECONDARY);
  assign wr1 = CE && REQ.wr && hit(REQ, PEVIF_OFF_PRIMARY);
  assign wr2 = CE && REQ.wr && hit(REQ, PEVIF_OFF_SECONDARY);
  assign wrc = CE && REQ.wr && hit(REQ, PEVIF_OFF_CTRL);

  // A read clears the flags it returns, but an event landing in that same
  // cycle is kept so that it is reported by the next read.
  always_comb begin
    flags1_d = flags1_q & ~{PEVIF_FLAG_W{clr1}}; // R23
    flags1_d = flags1_d | ev1; // R1 R2 R3 R4 R5 R6 R7 R8
    flags2_d = flags2_q & ~{PEVIF_FLAG_W{clr2}}; // R23
    flags2_d = flags2_d | ev2; // R10 R11 R12 R13 R14 R15 R16 R17
  end

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      flags1_q <= PEVIF_RST_PRIMARY[PEVIF_FLAG_LSB +: PEVIF_FLAG_W];
      flags2_q <= PEVIF_RST_SECONDARY[PEVIF_FLAG_LSB +: PEVIF_FLAG_W];
    end else if (CE) begin
      flags1_q <= flags1_d;
      flags2_q <= flags2_d;
    end
  end

  // Enables change only by writes; reads leave them alone.
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      en1_q <= PEVIF_RST_PRIMARY[PEVIF_EN_LSB +: PEVIF_FLAG_W];
      en2_q <= PEVIF_RST_SECONDARY[PEVIF_EN_LSB +: PEVIF_FLAG_W]; // R18
    end else begin
      if (wr1) begin
        en1_q <= REQ.wdata[PEVIF_EN_LSB +: PEVIF_FLAG_W]; // R9
      end
      if (wr2) begin
        en2_q <= REQ.wdata[PEVIF_EN_LSB +: PEVIF_FLAG_W]; // R18
      end
    end
  end

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      ctrl_q <= PEVIF_RST_CTRL; // R20
    end else if (wrc) begin
      ctrl_q <= REQ.wdata[PEVIF_CTRL_W-1:0];
    end
  end

  // Read data is captured on the read cycle, before the clear lands.
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      rdata_q <= 16'h0000;
      rvalid_q <= 1'b0;
    end else if (CE) begin
      rvalid_q <= REQ.rd;
      if (REQ.rd) begin
        if (hit(REQ, PEVIF_OFF_PRIMARY)) begin
          rdata_q <= {flags1_q, en1_q};
        end else if (hit(REQ, PEVIF_OFF_SECONDARY)) begin
          rdata_q <= {flags2_q, en2_q};
        end else if (hit(REQ, PEVIF_OFF_CTRL)) begin
          rdata_q <= {12'h000, ctrl_q};
        end else begin
          rdata_q <= 16'h0000;
        end
      end
    end
  end

  assign irq_active = ctrl_q[PEVIF_CTRL_TEST] || // R21
                      (ctrl_q[PEVIF_CTRL_GEN] && // R19
                       (|(flags1_q & en1_q) || |(flags2_q & en2_q))); // R24

  // The pin level is registered so that it never glitches while flags and
  // enables change together.
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      irq_pin_q <= PEVIF_RST_CTRL[PEVIF_CTRL_POL];
      pd_level_q <= 1'b0;
    end else if (CE) begin
      irq_pin_q <= ctrl_q[PEVIF_CTRL_POL] ? ~irq_active : irq_active; // R20
      pd_level_q <= ctrl_q[PEVIF_CTRL_OE] ? 1'b0 : IRQ_OR_POWERDOWN_PIN_I; // R22
    end
  end

  assign IRQ_OR_POWERDOWN_PIN_O = irq_pin_q;
  assign IRQ_OR_POWERDOWN_PIN_OE_N = ~ctrl_q[PEVIF_CTRL_OE]; // R22
  assign POWERDOWN_LEVEL = pd_level_q;
  assign IRQ_ACTIVE = irq_active;
  assign RDATA = rdata_q;
  assign RVALID = rvalid_q;

  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (RST);

  property p_link_quality_set;
    CE && EVT.link_quality |=> flags1_q[7];
  endproperty
  a_link_quality_set: assert property (p_link_quality_set) // R1
    else $error("link quality flag not set");

  property p_energy_cause;
    $rose(flags1_q[6]) |-> $past(CE && EVT.energy_detect);
  endproperty
  a_energy_cause: assert property (p_energy_cause) // R2
    else $error("energy flag rose without event");

  property p_link_status_held;
    CE && EVT.link_status ##1 !clr1 |=> flags1_q[5];
  endproperty
  a_link_status_held: assert property (p_link_status_held) // R3
    else $error("link status flag lost without read");

  property p_wol_shared;
    CE && (EVT.wol_packet || EVT.polarity_inverted) |=> flags2_q[1];
  endproperty
  a_wol_shared: assert property (p_wol_shared) // R16
    else $error("shared polarity or wake flag not set");

  property p_jabber_set;
    CE && EVT.jabber |=> flags2_q[0];
  endproperty
  a_jabber_set: assert property (p_jabber_set) // R17
    else $error("jabber flag not set");

  property p_speed_set;
    CE && EVT.speed |=> flags1_q[4];
  endproperty
  a_speed_set: assert property (p_speed_set) // R4
    else $error("speed flag not set");

  property p_duplex_set;
    CE && EVT.duplex |=> flags1_q[3];
  endproperty
  a_duplex_set: assert property (p_duplex_set) // R5
    else $error("duplex flag not set");

  property p_autoneg_done_set;
    CE && EVT.autoneg_done |=> flags1_q[2];
  endproperty
  a_autoneg_done_set: assert property (p_autoneg_done_set) // R6
    else $error("negotiation complete flag not set");

  property p_false_carrier_set;
    CE && EVT.false_carrier_half |=> flags1_q[1];
  endproperty
  a_false_carrier_set: assert property (p_false_carrier_set) // R7
    else $error("false carrier half-full flag not set");

  property p_rx_error_set;
    CE && EVT.rx_error_half |=> flags1_q[0];
  endproperty
  a_rx_error_set: assert property (p_rx_error_set) // R8
    else $error("receive error half-full flag not set");

  property p_eee_set;
    CE && EVT.eee_error |=> flags2_q[7];
  endproperty
  a_eee_set: assert property (p_eee_set) // R10
    else $error("efficient ethernet error flag not set");

  property p_eee_cause;
    $rose(flags2_q[7]) |-> $past(CE && EVT.eee_error);
  endproperty
  a_eee_cause: assert property (p_eee_cause) // R10
    else $error("efficient ethernet error flag rose without event");

  property p_autoneg_error_set;
    CE && EVT.autoneg_error |=> flags2_q[6];
  endproperty
  a_autoneg_error_set: assert property (p_autoneg_error_set) // R11
    else $error("negotiation error flag not set");

  property p_page_set;
    CE && EVT.page_received |=> flags2_q[5];
  endproperty
  a_page_set: assert property (p_page_set) // R12
    else $error("page received flag not set");

  property p_loopback_set;
    CE && EVT.loopback_fifo_err |=> flags2_q[4];
  endproperty
  a_loopback_set: assert property (p_loopback_set) // R13
    else $error("loopback fifo flag not set");

  property p_crossover_set;
    CE && EVT.crossover |=> flags2_q[3];
  endproperty
  a_crossover_set: assert property (p_crossover_set) // R14
    else $error("crossover flag not set");

  property p_sleep_set;
    CE && EVT.sleep |=> flags2_q[2];
  endproperty
  a_sleep_set: assert property (p_sleep_set) // R15
    else $error("sleep flag not set");

  property p_read_clears;
    clr1 && ev1 == 8'h00 |=> flags1_q == 8'h00;
  endproperty
  a_read_clears: assert property (p_read_clears) // R23
    else $error("read did not clear primary flags");

  property p_read_returns;
    clr2 |=> RVALID && RDATA == {$past(flags2_q), $past(en2_q)};
  endproperty
  a_read_returns: assert property (p_read_returns) // R23
    else $error("secondary read data wrong");

  property p_enables_stable_on_read;
    REQ.rd && !wr1 |=> $stable(en1_q);
  endproperty
  a_enables_stable_on_read: assert property (p_enables_stable_on_read) // R9
    else $error("primary enables changed without a write");

  property p_enable_write;
    wr2 |=> en2_q == $past(REQ.wdata[7:0]);
  endproperty
  a_enable_write: assert property (p_enable_write) // R18
    else $error("secondary enables not written");

  property p_global_gate;
    !ctrl_q[PEVIF_CTRL_GEN] && !ctrl_q[PEVIF_CTRL_TEST] |-> !irq_active;
  endproperty
  a_global_gate: assert property (p_global_gate) // R19
    else $error("interrupt active while globally disabled");

  property p_polarity;
    CE |=> IRQ_OR_POWERDOWN_PIN_O == ($past(ctrl_q[3]) ^ $past(irq_active));
  endproperty
  a_polarity: assert property (p_polarity) // R20
    else $error("pin level does not follow polarity");

  property p_test_forces;
    ctrl_q[PEVIF_CTRL_TEST] |-> irq_active;
  endproperty
  a_test_forces: assert property (p_test_forces) // R21
    else $error("test bit did not force interrupt");

  property p_output_enable;
    IRQ_OR_POWERDOWN_PIN_OE_N == !ctrl_q[PEVIF_CTRL_OE];
  endproperty
  a_output_enable: assert property (p_output_enable) // R22
    else $error("pin direction does not follow output enable");

  property p_irq_from_event;
    ctrl_q[PEVIF_CTRL_GEN] && CE && EVT.speed && en1_q[4] && !clr1 &&
    !wr1 && !wrc |=> irq_active;
  endproperty
  a_irq_from_event: assert property (p_irq_from_event) // R24
    else $error("enabled event did not raise interrupt");

  c_event_irq: cover property (CE && EVT.duplex ##1 irq_active && !ctrl_q[2]);
  c_test_irq: cover property (ctrl_q[PEVIF_CTRL_TEST] && ctrl_q[PEVIF_CTRL_OE]);
  c_clear_race: cover property (clr1 && ev1 != 8'h00);
  c_read_clear: cover property (flags2_q != 8'h00 ##1 clr2 ##1 flags2_q == 8'h00);
  c_frozen_event: cover property (!CE && EVT.wol_packet ##1 !flags2_q[1]);

endmodule
`default_nettype wire

// [tb/pevif_mgmt_model.sv]
`timescale 1ns/1ps
`default_nettype none
// Management station: one strobe per access, and afterwards it drops the strobe and drives the inverted address.
module pevif_mgmt_model (
  // Clock.
  input wire logic clk,
  // Register bus.
  output var pevif_pkg::pevif_req_t req,
  input wire logic [15:0] rdata,
  input wire logic rvalid
);
  import pevif_pkg::*;
  initial req = '0;
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk);
    #1 req = '{1'b0, 1'b1, a, d};
    @(posedge clk);
    #1 req = '{1'b0, 1'b0, ~a, ~d};
  endtask
  // Read data is taken only while the answer is flagged valid.
  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    @(posedge clk);
    #1 req = '{1'b1, 1'b0, a, 16'hFFFF};
    @(posedge clk);
    #1 req = '{1'b0, 1'b0, ~a, 16'h0000};
    d = rvalid ? rdata : 16'hXXXX;
  endtask
endmodule
`default_nettype wire

// [tb/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import pevif_pkg::*;
  logic clk_sys, rst, cen, pd_drive, rvalid, pin_o, pin_oe_n, pd_level, irq;
  logic [15:0] rdata;
  pevif_req_t req;
  pevif_evt_t evt;
  wire logic pin_i;
  int bad_count, samples_checked;
  // The pin carries our level only while the block leaves it as an input.
  assign pin_i = pin_oe_n ? pd_drive : pin_o;
  pevif_top uut (
    .CLK_SYS(clk_sys),
    .RST(rst),
    .CE(cen),
    .REQ(req),
    .RDATA(rdata),
    .RVALID(rvalid),
    .EVT(evt),
    .IRQ_OR_POWERDOWN_PIN_I(pin_i),
    .IRQ_OR_POWERDOWN_PIN_O(pin_o),
    .IRQ_OR_POWERDOWN_PIN_OE_N(pin_oe_n),
    .POWERDOWN_LEVEL(pd_level),
    .IRQ_ACTIVE(irq)
  );
  pevif_mgmt_model mgmt (
    .clk(clk_sys),
    .req(req),
    .rdata(rdata),
    .rvalid(rvalid)
  );
  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp, input string msg);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp, input string msg);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t %s got %b exp %b", $time, msg, got, exp);
    end
  endtask
  task automatic pulse(input int i);
    @(posedge clk_sys);
    #1 evt = pevif_evt_t'(17'h00001 << i);
    @(posedge clk_sys);
    #1 evt = '0;
  endtask
  task automatic settle();
    @(posedge clk_sys);
    #1;
  endtask
  task automatic test_reset();
    logic [15:0] d;
    mgmt.rd(PEVIF_OFF_PRIMARY, d);
    chk_word(d, 16'h0000, "primary reset");
    mgmt.rd(PEVIF_OFF_SECONDARY, d);
    chk_word(d, 16'h0000, "secondary reset");
    mgmt.rd(PEVIF_OFF_CTRL, d);
    chk_word(d, 16'h0008, "ctrl reset");
    mgmt.rd(5'h1F, d);
    chk_word(d, 16'h0000, "unmapped read");
    chk_bit(pin_o, 1'b1, "idle pin level");
    chk_bit(pin_oe_n, 1'b1, "pin is input");
    $display("test_reset done");
  endtask
  // Each event source, last in package order first, lands on its flag (polarity and wake share one), which a read then clears.
  task automatic test_events();
    logic [15:0] d, e;
    logic [4:0] a;
    for (int i = 0; i < 17; i++) begin
      a = (i > 8) ? PEVIF_OFF_PRIMARY : PEVIF_OFF_SECONDARY;
      e = 16'h0001 << ((i > 8) ? i - 1 : (i > 1) ? i + 7 : i + 8);
      pulse(i);
      chk_bit(irq, 1'b0, "no enable no irq");
      mgmt.rd(a, d);
      chk_word(d, e, "flag set");
      mgmt.rd(a, d);
      chk_word(d, 16'h0000, "flag cleared");
    end
    $display("test_events done");
  endtask
  task automatic test_irq();
    logic [15:0] d;
    mgmt.wr(PEVIF_OFF_PRIMARY, 16'hFFEF);
    mgmt.wr(PEVIF_OFF_CTRL, 16'h0009);
    pulse(13);
    chk_bit(irq, 1'b0, "global enable off");
    mgmt.wr(PEVIF_OFF_CTRL, 16'h000B);
    chk_bit(irq, 1'b0, "speed enable off");
    mgmt.wr(PEVIF_OFF_PRIMARY, 16'h00FF);
    chk_bit(irq, 1'b1, "enabled flag");
    settle();
    chk_bit(pin_o, 1'b0, "active low pin");
    chk_bit(pin_oe_n, 1'b0, "pin driven");
    mgmt.rd(PEVIF_OFF_PRIMARY, d);
    chk_word(d, 16'h10FF, "flag and enables");
    chk_bit(irq, 1'b0, "irq gone after read");
    mgmt.rd(PEVIF_OFF_PRIMARY, d);
    chk_word(d, 16'h00FF, "enables kept");
    mgmt.wr(PEVIF_OFF_SECONDARY, 16'hFFFF);
    mgmt.rd(PEVIF_OFF_SECONDARY, d);
    chk_word(d, 16'h00FF, "flags not writable");
    mgmt.wr(PEVIF_OFF_CTRL, 16'h0005);
    settle();
    chk_bit(pin_o, 1'b1, "test irq high");
    mgmt.wr(PEVIF_OFF_CTRL, 16'h0001);
    settle();
    chk_bit(pin_o, 1'b0, "idle low");
    pd_drive = 1'b1;
    mgmt.wr(PEVIF_OFF_CTRL, 16'h0000);
    settle();
    chk_bit(pin_oe_n, 1'b1, "pin released");
    chk_bit(pd_level, 1'b1, "power-down level");
    $display("test_irq done");
  endtask
  // Secondary enables gate the output, a low clock enable freezes events, writes and
  // the output, and a reset in mid-run brings enables and control back to defaults.
  task automatic test_hold();
    logic [15:0] d;
    mgmt.wr(PEVIF_OFF_CTRL, 16'h000B);
    pulse(13);
    chk_bit(irq, 1'b1, "speed event raises irq");
    mgmt.wr(PEVIF_OFF_SECONDARY, 16'h00FE);
    pulse(0);
    mgmt.rd(PEVIF_OFF_PRIMARY, d);
    chk_word(d, 16'h10FF, "speed flag");
    chk_bit(irq, 1'b0, "jabber enable off");
    mgmt.wr(PEVIF_OFF_SECONDARY, 16'h00FF);
    chk_bit(irq, 1'b1, "jabber enable on");
    cen = 1'b0;
    pulse(1);
    mgmt.wr(PEVIF_OFF_CTRL, 16'h0000);
    chk_bit(irq, 1'b1, "control frozen");
    cen = 1'b1;
    mgmt.rd(PEVIF_OFF_SECONDARY, d);
    chk_word(d, 16'h01FF, "frozen event ignored");
    chk_bit(irq, 1'b0, "irq gone after read");
    rst = 1'b1;
    settle();
    rst = 1'b0;
    mgmt.rd(PEVIF_OFF_SECONDARY, d);
    chk_word(d, 16'h0000, "enables reset mid-run");
    mgmt.rd(PEVIF_OFF_CTRL, d);
    chk_word(d, 16'h0008, "ctrl reset mid-run");
    $display("test_hold done");
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  // The tests need well under a thousand cycles.
  initial begin
    #120000;
    bad_count++;
    wrap_up();
  end
  initial begin
    rst = 1'b1;
    evt = '0;
    pd_drive = 1'b0;
    cen = 1'b1;
    bad_count = 0;
    samples_checked = 0;
    repeat (20) @(posedge clk_sys);
    #1 rst = 1'b0;
    test_reset();
    test_events();
    test_irq();
    test_hold();
    wrap_up();
  end
endmodule
`default_nettype wire
